// File: hdl/sps_sequencer.sv
/*
 * sps_sequencer: sleep/wake power sequencer with its register file,
 * dwell counter, wake detection and supply/clock control outputs.
 * assumes: one 10 MHz clock; wake pin and slow oscillator tick come
 * from outside and are synchronised here; real-time count and supply
 * good flags come from logic on the same clock.
 */
`timescale 1ns/1ps

module sps_sequencer
   import sps_pkg::*;
(
   // clock and reset
   input  wire logic                clock_in,
   input  wire logic                rst_in,
   // register port
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic [31:0]         reg_wdata_in,
   output logic      [31:0]         reg_rdata_out,
   // wake sources
   input  wire logic                wake_pin_in,
   input  wire logic                slow_osc_tick_in,
   input  wire logic [63:0]         rtc_count_in,
   // supply feedback, {io, pll, analog, core}
   input  wire logic [3:0]          supply_good_in,
   // supply and clock control
   output logic                     core_switcher_en_out,
   output logic                     analog_switcher_en_out,
   output logic                     pll_regulator_en_out,
   output logic                     io_supply_output_en_out,
   output logic                     core_switcher_pfm_out,
   output logic                     analog_switcher_pfm_out,
   output logic                     tile_clock_off_out,
   output logic                     sleep_clk_default_out,
   output logic                     use_por_levels_out,
   output logic      [31:0]         core_level_out,
   output logic      [31:0]         pll_level_out,
   output logic      [31:0]         switcher_ctrl_out,
   output sps_pkg::sps_state_t      state_out
);
   import sps_pkg::*;

   // dwell limit: 2^n cycles means count reaches 2^n - 1
   function automatic logic [31:0] dwell_limit(input logic [31:0] cfg);
      logic [4:0] n;
      n = cfg[CFG_DWELL_MSB:CFG_DWELL_LSB];
      dwell_limit = (32'h00000001 << n) - 32'h00000001;
   endfunction

   // masked word update keeps read-only bits untouched
   function automatic logic [31:0] masked_write(input logic [31:0] old,
                                                input logic [31:0] wdata,
                                                input logic [31:0] mask);
      masked_write = (old & ~mask) | (wdata & mask);
   endfunction

   function automatic logic [31:0] cfg_reset(input int idx);
      unique case (idx)
         0:       cfg_reset = RST_DORMANT_CFG;
         1:       cfg_reset = RST_WAKE_ONE_CFG;
         2:       cfg_reset = RST_WAKE_TWO_CFG;
         3:       cfg_reset = RST_RUN_CFG;
         4:       cfg_reset = RST_SLEEP_ONE_CFG;
         default: cfg_reset = RST_SLEEP_TWO_CFG;
      endcase
   endfunction

   // registers
   logic [7:0]              gen_ctrl_r;
   logic [31:0]             wake_low_r;
   logic [31:0]             wake_high_r;
   logic [31:0]             cfg_r [NUM_STATES];
   logic [31:0]             switcher_ctrl_r;
   logic [31:0]             core_level_r;
   logic [31:0]             pll_level_r;
   sps_state_t              state_r;
   sps_state_t              state_nxt;
   logic [31:0]             dwell_cnt_r;
   logic [31:0]             applied_r;
   logic                    sleep_req_pulse;
   logic                    apply_pulse;

   // synchronisers
   logic                    wake_pin_s1_r;
   logic                    wake_pin_s2_r;
   logic                    slow_s1_r;
   logic                    slow_s2_r;
   logic                    slow_s3_r;
   logic                    slow_edge;

   // decode
   logic                    cfg_sel;
   logic [7:0]              cfg_ofs;
   logic [2:0]              cfg_idx;
   logic                    wr_gen;
   logic                    state_change;
   logic [31:0]             cur_cfg;
   logic                    dwell_tick;
   logic                    dwell_done;
   logic                    timer_match;
   logic                    pin_match;
   logic                    wake_event;
   logic                    supplies_good;
   logic [3:0]              enabled_mask;

   // external levels pass two flops before use
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wake_pin_s1_r <= 1'b0;
         wake_pin_s2_r <= 1'b0;
         slow_s1_r     <= 1'b0;
         slow_s2_r     <= 1'b0;
         slow_s3_r     <= 1'b0;
      end else begin
         wake_pin_s1_r <= wake_pin_in;
         wake_pin_s2_r <= wake_pin_s1_r;
         slow_s1_r     <= slow_osc_tick_in;
         slow_s2_r     <= slow_s1_r;
         slow_s3_r     <= slow_s2_r;
      end
   end

   assign slow_edge = slow_s2_r & ~slow_s3_r;

   // address decode, whole-word accesses only
   assign cfg_ofs = reg_addr_in - OFS_DORMANT_CFG;
   assign cfg_sel = (reg_addr_in >= OFS_DORMANT_CFG) && (reg_addr_in <= OFS_SLEEP_TWO_CFG)
                    && (reg_addr_in[1:0] == 2'b00);
   assign cfg_idx = cfg_ofs[4:2];
   assign wr_gen  = reg_wr_in && (reg_addr_in == OFS_GEN_CTRL);

   // self-clearing strobes never stored
   assign sleep_req_pulse = wr_gen && reg_wdata_in[GEN_SLEEP_REQ] && (state_r == ST_RUN);
   assign apply_pulse     = wr_gen && reg_wdata_in[GEN_APPLY_RUN];

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         gen_ctrl_r <= GEN_CTRL_RESET;
      end else if (wr_gen) begin
         gen_ctrl_r <= reg_wdata_in[7:0] & GEN_STORE_MASK;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wake_low_r  <= 32'h00000000;
         wake_high_r <= 32'h00000000;
      end else if (reg_wr_in) begin
         if (reg_addr_in == OFS_WAKE_LOW) begin
            wake_low_r <= reg_wdata_in;
         end
         if (reg_addr_in == OFS_WAKE_HIGH) begin
            wake_high_r <= reg_wdata_in;
         end
      end
   end

   // state configuration words; run word has no dwell field
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_STATES; i++) begin
            cfg_r[i] <= cfg_reset(i);
         end
      end else if (reg_wr_in && cfg_sel) begin
         if (cfg_idx == 3'(ST_RUN)) begin
            cfg_r[cfg_idx] <= masked_write(cfg_r[cfg_idx], reg_wdata_in, CFG_RUN_MASK);
         end else begin
            cfg_r[cfg_idx] <= masked_write(cfg_r[cfg_idx], reg_wdata_in,
                                           CFG_TIMED_MASK);
         end
      end
   end

   // layouts of these words are opaque here; stored and passed on
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         switcher_ctrl_r <= 32'h00000000;
         core_level_r    <= 32'h00000000;
         pll_level_r     <= 32'h00000000;
      end else if (reg_wr_in) begin
         if (reg_addr_in == OFS_SWITCHER_CTRL) begin
            switcher_ctrl_r <= reg_wdata_in;
         end
         if (reg_addr_in == OFS_CORE_LEVEL) begin
            core_level_r <= reg_wdata_in;
         end
         if (reg_addr_in == OFS_PLL_LEVEL) begin
            pll_level_r <= reg_wdata_in;
         end
      end
   end

   // read path, one cycle latency
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         if (cfg_sel) begin
            reg_rdata_out <= cfg_r[cfg_idx];
         end else begin
            unique case (reg_addr_in)
               OFS_GEN_CTRL:      reg_rdata_out <= {24'h000000, gen_ctrl_r};
               OFS_WAKE_LOW:      reg_rdata_out <= wake_low_r;
               OFS_WAKE_HIGH:     reg_rdata_out <= wake_high_r;
               OFS_SEQ_STATUS:    reg_rdata_out <= {29'h00000000, state_r};
               OFS_SWITCHER_CTRL: reg_rdata_out <= switcher_ctrl_r;
               OFS_SUPPLY_STATUS: reg_rdata_out <= {28'h0000000, supply_good_in};
               OFS_CORE_LEVEL:    reg_rdata_out <= core_level_r;
               OFS_PLL_LEVEL:     reg_rdata_out <= pll_level_r;
               default:           reg_rdata_out <= 32'h00000000;
            endcase
         end
      end
   end

   // wake detection; compare only consulted in dormant state
   always_comb begin
      if (gen_ctrl_r[GEN_WIDE_CMP]) begin
         timer_match = rtc_count_in >= {wake_high_r, wake_low_r};
      end else begin
         timer_match = rtc_count_in[31:0] >= wake_low_r;
      end
   end

   assign pin_match  = gen_ctrl_r[GEN_PIN_WAKE_EN]
                       && (wake_pin_s2_r == gen_ctrl_r[GEN_WAKE_POL]);
   assign wake_event = pin_match
                       || (gen_ctrl_r[GEN_TIMER_WAKE_EN] && timer_match);

   // dwell counting; dormant may run from the slow oscillator
   assign cur_cfg = cfg_r[state_r];
   always_comb begin
      if (state_r == ST_DORMANT && !gen_ctrl_r[GEN_SLEEP_CLK_SEL]) begin
         dwell_tick = slow_edge;
      end else begin
         dwell_tick = 1'b1;
      end
   end

   assign dwell_done = dwell_cnt_r >= dwell_limit(cur_cfg);

   // supplies not enabled in the applied word are don't-care
   assign enabled_mask  = {applied_r[CFG_IO_SUPPLY_EN], applied_r[CFG_PLL_REG_EN],
                           applied_r[CFG_ANALOG_SW_EN], applied_r[CFG_CORE_SW_EN]};
   assign supplies_good = &(supply_good_in | ~enabled_mask);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (sleep_req_pulse) begin
               state_nxt = ST_SLEEP_ONE;
            end
         end
         ST_SLEEP_ONE: begin
            if (dwell_done) begin
               state_nxt = ST_SLEEP_TWO;
            end
         end
         ST_SLEEP_TWO: begin
            if (dwell_done) begin
               state_nxt = ST_DORMANT;
            end
         end
         ST_DORMANT: begin
            if (dwell_done && wake_event) begin
               state_nxt = ST_WAKE_ONE;
            end
         end
         ST_WAKE_ONE: begin
            if (dwell_done && supplies_good) begin
               state_nxt = ST_WAKE_TWO;
            end
         end
         ST_WAKE_TWO: begin
            if (dwell_done && supplies_good) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   assign state_change = (state_nxt != state_r);

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // counter restarts on entry and saturates at its limit
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         dwell_cnt_r <= 32'h00000000;
      end else if (state_change) begin
         dwell_cnt_r <= 32'h00000000;
      end else if (dwell_tick && !dwell_done) begin
         dwell_cnt_r <= dwell_cnt_r + 32'h00000001;
      end
   end

   // applied word latched on entry so edits to the run word wait for apply
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         applied_r <= RST_RUN_CFG;
      end else if (state_change) begin
         applied_r <= cfg_r[state_nxt];
      end else if (apply_pulse && state_r == ST_RUN) begin
         applied_r <= cfg_r[ST_RUN];
      end
   end

   // supply, regulator mode and tile clock controls
   assign core_switcher_en_out    = applied_r[CFG_CORE_SW_EN];
   assign analog_switcher_en_out  = applied_r[CFG_ANALOG_SW_EN];
   assign pll_regulator_en_out    = applied_r[CFG_PLL_REG_EN];
   assign io_supply_output_en_out = applied_r[CFG_IO_SUPPLY_EN];
   assign core_switcher_pfm_out   = applied_r[CFG_CORE_SW_PFM];
   assign analog_switcher_pfm_out = applied_r[CFG_ANALOG_SW_PFM];
   assign tile_clock_off_out      = applied_r[CFG_TILE_CLK_OFF];

   // sleep clock choice only matters while dormant
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sleep_clk_default_out <= 1'b1;
      end else if (state_nxt == ST_DORMANT) begin
         sleep_clk_default_out <= gen_ctrl_r[GEN_SLEEP_CLK_SEL];
      end else begin
         sleep_clk_default_out <= 1'b1;
      end
   end

   // level selection latched on wake entry and held until the next wake entry
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         use_por_levels_out <= 1'b0;
      end else if (state_change && state_nxt == ST_WAKE_ONE) begin
         use_por_levels_out <= gen_ctrl_r[GEN_POR_LEVELS];
      end
   end

   assign core_level_out    = core_level_r;
   assign pll_level_out     = pll_level_r;
   assign switcher_ctrl_out = switcher_ctrl_r;
   assign state_out         = state_r;

endmodule

// File: include/sps_pkg.sv
/*
 * sps_pkg: register map, field positions, reset values and state type
 * for the sleep/wake power sequencer.
 * assumes: 32-bit word register port, byte addresses as printed.
 */
package sps_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_GEN_CTRL      = 8'h00;
   localparam logic [7:0] OFS_WAKE_LOW      = 8'h04;
   localparam logic [7:0] OFS_WAKE_HIGH     = 8'h08;
   localparam logic [7:0] OFS_DORMANT_CFG   = 8'h0c;
   localparam logic [7:0] OFS_WAKE_ONE_CFG  = 8'h10;
   localparam logic [7:0] OFS_WAKE_TWO_CFG  = 8'h14;
   localparam logic [7:0] OFS_RUN_CFG       = 8'h18;
   localparam logic [7:0] OFS_SLEEP_ONE_CFG = 8'h1c;
   localparam logic [7:0] OFS_SLEEP_TWO_CFG = 8'h20;
   localparam logic [7:0] OFS_SEQ_STATUS    = 8'h24;
   localparam logic [7:0] OFS_SWITCHER_CTRL = 8'h2c;
   localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h30;
   localparam logic [7:0] OFS_CORE_LEVEL    = 8'h34;
   localparam logic [7:0] OFS_PLL_LEVEL     = 8'h40;
   localparam logic [7:0] CFG_WORD_STEP     = 8'h04;

   // general control fields
   localparam int GEN_SLEEP_CLK_SEL = 0;
   localparam int GEN_SLEEP_REQ     = 1;
   localparam int GEN_PIN_WAKE_EN   = 2;
   localparam int GEN_WAKE_POL      = 3;
   localparam int GEN_TIMER_WAKE_EN = 4;
   localparam int GEN_WIDE_CMP      = 5;
   localparam int GEN_APPLY_RUN     = 6;
   localparam int GEN_POR_LEVELS    = 7;
   localparam logic [7:0] GEN_CTRL_RESET = 8'h08;
   localparam logic [7:0] GEN_STORE_MASK = 8'hbd;

   // state configuration word fields
   localparam int CFG_CORE_SW_EN    = 0;
   localparam int CFG_ANALOG_SW_EN  = 1;
   localparam int CFG_PLL_REG_EN    = 4;
   localparam int CFG_IO_SUPPLY_EN  = 5;
   localparam int CFG_CORE_SW_PFM   = 8;
   localparam int CFG_ANALOG_SW_PFM = 9;
   localparam int CFG_TILE_CLK_OFF  = 14;
   localparam int CFG_DWELL_LSB     = 16;
   localparam int CFG_DWELL_MSB     = 20;
   localparam logic [31:0] CFG_TIMED_MASK = 32'h001f4331;
   localparam logic [31:0] CFG_RUN_MASK   = 32'h00004331;

   // configuration reset values, one per state
   localparam logic [31:0] RST_DORMANT_CFG   = 32'h00100000;
   localparam logic [31:0] RST_WAKE_ONE_CFG  = 32'h00100020;
   localparam logic [31:0] RST_WAKE_TWO_CFG  = 32'h00100033;
   localparam logic [31:0] RST_RUN_CFG       = 32'h00000033;
   localparam logic [31:0] RST_SLEEP_ONE_CFG = 32'h00100022;
   localparam logic [31:0] RST_SLEEP_TWO_CFG = 32'h00100022;

   localparam int NUM_STATES = 6;

   // order matches the configuration word order in the map
   typedef enum logic [2:0] {
      ST_DORMANT,
      ST_WAKE_ONE,
      ST_WAKE_TWO,
      ST_RUN,
      ST_SLEEP_ONE,
      ST_SLEEP_TWO
   } sps_state_t;

endpackage

// File: tb/sleep_wake_power_sequencer_tb.sv
/* sleep_wake_power_sequencer_tb: register and state model checked at
   every read and state change.
   assumes: sps_pkg compiled first; sps_supply_model plays the rails. */
`timescale 1ns/1ps
module sleep_wake_power_sequencer_tb;
   import sps_pkg::*;
   logic clock_in, rst_in, reg_wr_in, reg_rd_in, wake_pin_in, slow_osc_tick_in;
   logic core_switcher_en_out, analog_switcher_en_out, pll_regulator_en_out;
   logic io_supply_output_en_out, core_switcher_pfm_out, analog_switcher_pfm_out;
   logic tile_clock_off_out, sleep_clk_default_out, use_por_levels_out;
   logic [7:0]  reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, core_level_out, pll_level_out, switcher_ctrl_out;
   logic [63:0] rtc_count_in;
   logic [3:0]  supply_good_in;
   logic [6:0]  outs;
   sps_state_t  state_out, last_st;
   int          fails, num_checks, cyc;
   int unsigned regs_m [17];
   logic [31:0] seq_cfg [3:8] = '{32'h00024300, 32'h00010020, 32'h00010033, 32'h0,
                                  32'h00010122, 32'h00000022};
   logic [7:0]  mode_gen [5] = '{8'h0c, 8'h85, 8'h19, 8'h39, 8'h3d};
   logic [31:0] mode_hi [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h1};
   int          mode_ofs [5] = '{0, 0, 200, 200, 100};
   logic        mode_pin [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   assign outs = {tile_clock_off_out, analog_switcher_pfm_out, core_switcher_pfm_out,
                  io_supply_output_en_out, pll_regulator_en_out, analog_switcher_en_out,
                  core_switcher_en_out};
   sps_sequencer uut (.clock_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
      .reg_rdata_out, .wake_pin_in, .slow_osc_tick_in, .rtc_count_in, .supply_good_in,
      .core_switcher_en_out, .analog_switcher_en_out, .pll_regulator_en_out,
      .io_supply_output_en_out, .core_switcher_pfm_out, .analog_switcher_pfm_out,
      .tile_clock_off_out, .sleep_clk_default_out, .use_por_levels_out, .core_level_out,
      .pll_level_out, .switcher_ctrl_out, .state_out);
   sps_supply_model u_supply (.clock_in, .rst_in, .enable_in({io_supply_output_en_out,
      pll_regulator_en_out, analog_switcher_en_out, core_switcher_en_out}),
      .good_out(supply_good_in), .slow_osc_out(slow_osc_tick_in));
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   always @(posedge clock_in) rtc_count_in <= rtc_count_in + 64'h1;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [6:0] pack(input logic [31:0] w);
      return {w[14], w[9], w[8], w[5], w[4], w[1], w[0]};
   endfunction
   function automatic logic [31:0] wmask(input logic [7:0] a);
      if (a == OFS_GEN_CTRL) return 32'h000000bd;
      if (a == OFS_RUN_CFG) return 32'h00004331;
      if (a >= OFS_DORMANT_CFG && a <= OFS_SLEEP_TWO_CFG) return 32'h001f4331;
      if (a inside {8'h04, 8'h08, 8'h2c, 8'h34, 8'h40}) return 32'hffffffff;
      return 32'h0;
   endfunction
   // strobe edge then one idle edge, so back-to-back calls never re-assign in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
      regs_m[a[7:2]] = (regs_m[a[7:2]] & ~wmask(a)) | (d & wmask(a));
      @(posedge clock_in);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      @(negedge clock_in);
      check($sformatf("reg %h", a), reg_rdata_out, exp);
      @(posedge clock_in);
   endtask
   task automatic wait_state(input sps_state_t s);
      int n;
      n = 0;
      while (state_out !== s && n < 3000) begin
         @(negedge clock_in);
         n++;
      end
      check("reach state", state_out, s);
      @(posedge clock_in);
   endtask
   task automatic do_reset();
      rst_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      foreach (regs_m[i]) regs_m[i] = 0;
      regs_m[0] = 32'h08;
      regs_m[3] = 32'h00100000;
      regs_m[4] = 32'h00100020;
      regs_m[5] = RST_WAKE_TWO_CFG;
      regs_m[6] = RST_RUN_CFG;
      regs_m[7] = RST_SLEEP_ONE_CFG;
      regs_m[8] = RST_SLEEP_TWO_CFG;
      regs_m[9] = 32'h3;
   endtask
   always @(negedge clock_in) begin
      if (rst_in)
         last_st = ST_RUN;
      else if (state_out !== last_st) begin
         check("state", state_out, (last_st == ST_SLEEP_TWO) ? 32'h0 : last_st + 32'h1);
         check("supply outputs", outs, pack(regs_m[3 + state_out]));
         if (state_out == ST_WAKE_ONE)
            check("por levels", use_por_levels_out, regs_m[0][7]);
         if (state_out == ST_DORMANT)
            check("sleep clock", sleep_clk_default_out, regs_m[0][0]);
         last_st = state_out;
      end
   end
   task automatic sleep_cycle(input logic [7:0] g, input logic [31:0] hi, input int ofs,
                              input logic pin);
      logic [31:0] lo;
      int t0;
      wake_pin_in <= ~pin;
      lo = rtc_count_in[31:0] + 32'(ofs);
      wr(OFS_WAKE_LOW, lo);
      wr(OFS_WAKE_HIGH, hi);
      wr(OFS_GEN_CTRL, {24'h0, g} | 32'h2);
      wait_state(ST_DORMANT);
      t0 = cyc;
      wr(OFS_GEN_CTRL, {24'h0, g & 8'hfb});
      repeat (150) @(posedge clock_in);
      check("dormant hold", state_out, ST_DORMANT);
      wr(OFS_GEN_CTRL, {24'h0, g});
      wake_pin_in <= pin;
      wait_state(ST_WAKE_ONE);
      if (g[4] && !g[2])
         check("timer wake", 32'(rtc_count_in[31:0] - lo < 32'd12), 32'h1);
      if (!g[0])
         check("slow dwell", 32'(cyc - t0 >= 640), 32'h1);
      wait_state(ST_RUN);
   endtask
   initial begin
      rst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h0;
      reg_wdata_in = 32'h0;
      wake_pin_in = 1'b0;
      rtc_count_in = 64'h0;
      fails = 0;
      num_checks = 0;
      cyc = 0;
      void'($urandom(33));
      do_reset();
      for (int a = 0; a < 17; a++)
         if (a != 12) rd_chk(8'(a * 4), regs_m[a]);
      rd_chk(OFS_SUPPLY_STATUS, {28'h0, supply_good_in});
      for (int a = 1; a < 17; a++)
         if (a != 9 && a != 12) begin
            wr(8'(a * 4), $urandom);
            rd_chk(8'(a * 4), regs_m[a]);
         end
      wr(OFS_GEN_CTRL, $urandom & 32'hffffffbd);
      rd_chk(OFS_GEN_CTRL, regs_m[0]);
      check("core level", core_level_out, regs_m[13]);
      check("pll level", pll_level_out, regs_m[16]);
      check("switcher ctrl", switcher_ctrl_out, regs_m[11]);
      do_reset();
      wr(OFS_RUN_CFG, 32'h00004101);
      @(negedge clock_in);
      check("before apply", outs, pack(32'h33));
      @(posedge clock_in);
      wr(OFS_GEN_CTRL, 32'h48);
      @(negedge clock_in);
      check("after apply", outs, pack(regs_m[6]));
      @(posedge clock_in);
      for (int a = 3; a < 9; a++)
         if (a != 6) wr(8'(a * 4), seq_cfg[a]);
      for (int m = 0; m < 5; m++)
         sleep_cycle(mode_gen[m], mode_hi[m], mode_ofs[m], mode_pin[m]);
      print_verdict();
   end
endmodule

// File: tb/sps_sequencer_asserts.sv
/* sps_sequencer_asserts: port-level properties of the power sequencer.
   assumes: bound into sps_sequencer; mirrors the control writes it sees. */
`timescale 1ns/1ps
module sps_sequencer_asserts
   import sps_pkg::*;
(
   // clock, reset, register port
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   // supplies, clocks, state
   input wire logic [3:0]  supply_good_in,
   input wire logic        core_switcher_en_out,
   input wire logic        analog_switcher_en_out,
   input wire logic        pll_regulator_en_out,
   input wire logic        io_supply_output_en_out,
   input wire logic        tile_clock_off_out,
   input wire logic        sleep_clk_default_out,
   input sps_state_t       state_out
);
   logic [7:0]  gen_r;
   logic [4:0]  dwell_r;
   logic [31:0] cnt_r;
   logic [3:0]  en_w;
   logic        gen_wr;
   assign en_w = {io_supply_output_en_out, pll_regulator_en_out,
                  analog_switcher_en_out, core_switcher_en_out};
   assign gen_wr = reg_wr_in && reg_addr_in == OFS_GEN_CTRL;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         gen_r <= 8'h08;
         dwell_r <= 5'h10;
      end else begin
         if (gen_wr)
            gen_r <= reg_wdata_in[7:0] & 8'hbd;
         if (reg_wr_in && reg_addr_in == OFS_SLEEP_ONE_CFG)
            dwell_r <= reg_wdata_in[20:16];
      end
   end
   // cycles already spent in sleep entry one
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         cnt_r <= 32'h0;
      else if (state_out != ST_SLEEP_ONE)
         cnt_r <= 32'h0;
      else
         cnt_r <= cnt_r + 32'h1;
   end
   function automatic sps_state_t succ(input sps_state_t s);
      return (s == ST_SLEEP_TWO) ? ST_DORMANT : sps_state_t'(s + 3'h1);
   endfunction
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   state_order_a: assert property (
      !$stable(state_out) |-> state_out == succ($past(state_out))) else $error("bad state order");
   sleep_req_a: assert property (
      gen_wr && reg_wdata_in[1] && state_out == ST_RUN |=> state_out == ST_SLEEP_ONE)
      else $error("sleep request not taken");
   ctrl_read_a: assert property (
      reg_rd_in && reg_addr_in == OFS_GEN_CTRL && !reg_wr_in |=> reg_rdata_out == {24'h0, gen_r})
      else $error("control read wrong");
   dormant_hold_a: assert property (
      state_out == ST_DORMANT && !gen_r[2] && !gen_r[4] |=> state_out == ST_DORMANT)
      else $error("left dormant without wake source");
   wake_supply_a: assert property (
      state_out inside {ST_WAKE_ONE, ST_WAKE_TWO} && (en_w & ~supply_good_in) != 4'h0
      |=> $stable(state_out)) else $error("wake phase left with supply not good");
   outs_stable_a: assert property (
      $stable(state_out) && !$past(gen_wr) |-> $stable(en_w) && $stable(tile_clock_off_out))
      else $error("supply outputs moved without cause");
   dwell_hold_a: assert property (
      state_out == ST_SLEEP_ONE && cnt_r < (32'h1 << dwell_r) - 32'h1
      |=> state_out == ST_SLEEP_ONE) else $error("dwell cut short");
   dwell_leave_a: assert property (
      state_out == ST_SLEEP_ONE && cnt_r >= (32'h1 << dwell_r) - 32'h1
      |=> state_out == ST_SLEEP_TWO) else $error("dwell overran");
   sleep_clk_a: assert property (
      sleep_clk_default_out == (state_out != ST_DORMANT || gen_r[0]))
      else $error("sleep clock select wrong");
endmodule
bind sps_sequencer sps_sequencer_asserts u_asserts (.clock_in, .rst_in, .reg_wr_in, .reg_rd_in,
   .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .supply_good_in, .core_switcher_en_out,
   .analog_switcher_en_out, .pll_regulator_en_out, .io_supply_output_en_out,
   .tile_clock_off_out, .sleep_clk_default_out, .state_out);

// File: tb/sps_supply_model.sv
/* sps_supply_model: regulators that report good a while after being
   enabled, and the free-running slow oscillator.
   assumes: enables come from the sequencer on the system clock. */
`timescale 1ns/1ps
module sps_supply_model #(
   parameter int RAMP_CYCLES = 12,
   parameter int SLOW_HALF   = 160
) (
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // regulator side, {io, pll, analog, core}
   input  wire logic [3:0] enable_in,
   output logic      [3:0] good_out,
   // slow oscillator
   output logic            slow_osc_out
);
   int ramp_r [4];
   int half_r;
   // a disabled rail collapses at once, so good never lingers
   always @(posedge clock_in or posedge rst_in) begin
      for (int i = 0; i < 4; i++) begin
         if (rst_in || !enable_in[i])
            ramp_r[i] <= 0;
         else if (ramp_r[i] < RAMP_CYCLES)
            ramp_r[i] <= ramp_r[i] + 1;
         good_out[i] <= !rst_in && enable_in[i] && ramp_r[i] >= RAMP_CYCLES;
      end
   end
   initial begin
      slow_osc_out = 1'b0;
      half_r = 0;
   end
   // oscillator runs free, reset does not stop it
   always @(posedge clock_in) begin
      half_r <= (half_r == SLOW_HALF - 1) ? 0 : half_r + 1;
      if (half_r == SLOW_HALF - 1)
         slow_osc_out <= !slow_osc_out;
   end
endmodule
